// ===== include/fault_mask_consts.svh
`ifndef FAULT_MASK_CONSTS_SVH
`define FAULT_MASK_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_MODERATE_FAULT_ACTION_SELECT 8'h45
`define ADDR_GPIO_TRIGGER_MASK_LOW 8'h46
`define ADDR_GPIO_TRIGGER_MASK_MID 8'h47
`define ADDR_GPIO_TRIGGER_MASK_HIGH 8'h48

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODERATE_FAULT_ACTION_MSB 1
`define MODERATE_FAULT_ACTION_LSB 0
`define GPIO_COUNT 10
`define GPIO_PER_REG 4
`define HIGH_REG_USED_BITS 8'h0F

// ----------------------------------------
// Reset values when no default is loaded
// ----------------------------------------
`define RESET_ACTION_SELECT 8'h00
`define RESET_MASK_LOW 8'h00
`define RESET_MASK_MID 8'h00
`define RESET_MASK_HIGH 8'h00

`endif

// ===== include/fault_mask_pkg.sv
package fault_mask_pkg;

   typedef enum logic [1:0]
   {
      action_immediate_shutdown,
      action_orderly_shutdown,
      action_mcu_power_error,
      action_soc_power_error
   } fault_action_t;

   typedef struct packed
   {
      logic [7:0] action_select;
      logic [7:0] mask_low;
      logic [7:0] mask_mid;
      logic [7:0] mask_high;
      logic [7:0] read_data;
      logic [9:0] trigger;
   } state_t;

   typedef struct packed
   {
      logic [7:0] address;
      logic [7:0] write_data;
      logic write_strobe;
      logic read_strobe;
   } reg_request_t;

   typedef struct packed
   {
      logic [7:0] action_select;
      logic [7:0] mask_low;
      logic [7:0] mask_mid;
      logic [7:0] mask_high;
   } nvm_defaults_t;

endpackage : fault_mask_pkg

// ===== rtl/fault_action_and_gpio_trigger_mask.sv
`timescale 1ns/1ps
`include "fault_mask_consts.svh"

// Notes on behaviour
// - Two-bit field picks moderate fault response.
// - Defaults come from non-volatile memory contents.
// - Suppress bit zero passes pin, one masks.
// - Level bit sets value of masked trigger.
// - Low register holds GPIO1-4 in pairs.
// - Mid register holds GPIO5-8 in pairs.
// - High register GPIO9-10; bits 7:4 reserved.
// - Action register bits 7:2 reserved, stored and read back as written.

module fault_action_and_gpio_trigger_mask
(
   input wire logic clock,
   input wire logic resetn,
   input wire fault_mask_pkg::reg_request_t request,
   output logic [7:0] read_data,
   input wire fault_mask_pkg::nvm_defaults_t nvm_defaults,
   input wire logic nvm_load,
   input wire logic [9:0] gpio_level,
   output logic [9:0] gpio_trigger,
   output fault_mask_pkg::fault_action_t moderate_fault_action
);

   fault_mask_pkg::state_t state;
   fault_mask_pkg::state_t next_state;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Pair k of a mask byte: suppress at 2k, level at 2k+1
   function automatic logic [3:0] pick_suppress(input logic [7:0] r);
      pick_suppress = {r[6], r[4], r[2], r[0]};
   endfunction : pick_suppress

   function automatic logic [3:0] pick_level(input logic [7:0] r);
      pick_level = {r[7], r[5], r[3], r[1]};
   endfunction : pick_level

   logic [9:0] suppress;
   logic [9:0] level;
   logic [3:0] high_suppress;
   logic [3:0] high_level;

   // Only two pairs of the high byte carry pins; the rest is plain storage
   assign high_suppress = pick_suppress(state.mask_high);
   assign high_level = pick_level(state.mask_high);

   assign suppress = {high_suppress[1:0], pick_suppress(state.mask_mid),
      pick_suppress(state.mask_low)};
   assign level = {high_level[1:0], pick_level(state.mask_mid),
      pick_level(state.mask_low)};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.read_data = 8'h00;
      next_state.trigger = (gpio_level & ~suppress) | (level & suppress);
      if (nvm_load)
      begin
         next_state.action_select = nvm_defaults.action_select;
         next_state.mask_low = nvm_defaults.mask_low;
         next_state.mask_mid = nvm_defaults.mask_mid;
         next_state.mask_high = nvm_defaults.mask_high;
      end
      else if (request.write_strobe)
      begin
         if (request.address == `ADDR_MODERATE_FAULT_ACTION_SELECT)
         begin
            next_state.action_select = request.write_data;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_LOW)
         begin
            next_state.mask_low = request.write_data;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_MID)
         begin
            next_state.mask_mid = request.write_data;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_HIGH)
         begin
            next_state.mask_high = request.write_data;
         end
      end
      if (request.read_strobe)
      begin
         // Unmapped addresses read zero
         if (request.address == `ADDR_MODERATE_FAULT_ACTION_SELECT)
         begin
            next_state.read_data = state.action_select;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_LOW)
         begin
            next_state.read_data = state.mask_low;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_MID)
         begin
            next_state.read_data = state.mask_mid;
         end
         else if (request.address == `ADDR_GPIO_TRIGGER_MASK_HIGH)
         begin
            next_state.read_data = state.mask_high;
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         state.action_select <= `RESET_ACTION_SELECT;
         state.mask_low <= `RESET_MASK_LOW;
         state.mask_mid <= `RESET_MASK_MID;
         state.mask_high <= `RESET_MASK_HIGH;
         state.read_data <= 8'h00;
         state.trigger <= 10'h000;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign read_data = state.read_data;
   assign gpio_trigger = state.trigger;
   assign moderate_fault_action = fault_mask_pkg::fault_action_t'(
      state.action_select[`MODERATE_FAULT_ACTION_MSB:`MODERATE_FAULT_ACTION_LSB]);

endmodule : fault_action_and_gpio_trigger_mask

// ===== tb/fault_action_and_gpio_trigger_mask_test.sv
`timescale 1ns/1ps
module fault_action_and_gpio_trigger_mask_test;
   logic clock = 0;
   logic resetn = 0;
   fault_mask_pkg::reg_request_t request = '0;
   fault_mask_pkg::nvm_defaults_t nvm_defaults = 32'h0255AA0F;
   logic nvm_load = 0;
   logic [9:0] gpio_level = '0;
   logic [9:0] gpio_trigger;
   logic [7:0] read_data;
   fault_mask_pkg::fault_action_t moderate_fault_action;
   int n_errors = 0;
   int checked = 0;
   always #12.5 clock = ~clock;
   fault_action_and_gpio_trigger_mask dut_u
   (.clock(clock), .resetn(resetn), .request(request), .read_data(read_data),
    .nvm_defaults(nvm_defaults), .nvm_load(nvm_load), .gpio_level(gpio_level),
    .gpio_trigger(gpio_trigger), .moderate_fault_action(moderate_fault_action));
   task chk(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   // Strobe left up so a read may follow with no gap
   task wr(input logic [7:0] adr, input logic [7:0] dat);
      request <= '{adr, dat, 1'b1, 1'b0};
      @(posedge clock);
   endtask : wr
   task rd(input logic [7:0] adr, input logic [7:0] exp);
      request <= '{adr, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      request <= '0;
      #1 chk({2'b00, read_data}, {2'b00, exp});
      @(posedge clock);
   endtask : rd
   task complete_run;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd(8'(8'h45 + i), 8'h00);
      rd(8'h49, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h45, 8'(8'hFC | i));
         rd(8'h45, 8'(8'hFC | i));
         chk({8'h00, moderate_fault_action}, 10'(i));
      end
      wr(8'h47, 8'h93);
      wr(8'h48, 8'hFB);
      wr(8'h46, 8'h93);
      rd(8'h46, 8'h93);
      rd(8'h48, 8'hFB);
      rd(8'h47, 8'h93);
      gpio_level <= 10'h3FF;
      repeat (2) @(posedge clock);
      #1 chk(gpio_trigger, 10'h3BB);
      @(posedge clock) gpio_level <= 10'h000;
      repeat (2) @(posedge clock);
      #1 chk(gpio_trigger, 10'h111);
      // Write under load must lose
      @(posedge clock) nvm_load <= 1'b1;
      @(posedge clock);
      wr(8'h45, 8'h01);
      nvm_load <= 1'b0;
      rd(8'h45, 8'h02);
      rd(8'h46, 8'h55);
      chk({8'h00, moderate_fault_action}, 10'h002);
      resetn <= 1'b0;
      @(posedge clock) resetn <= 1'b1;
      rd(8'h46, 8'h00);
      complete_run();
   end
endmodule : fault_action_and_gpio_trigger_mask_test

// ===== tb/fault_mask_props.sv
`timescale 1ns/1ps
module fault_mask_props
(
   input wire logic clock,
   input wire logic resetn,
   input wire fault_mask_pkg::reg_request_t request,
   input wire logic [7:0] read_data,
   input wire fault_mask_pkg::nvm_defaults_t nvm_defaults,
   input wire logic nvm_load,
   input wire logic [9:0] gpio_level,
   input wire logic [9:0] gpio_trigger,
   input wire fault_mask_pkg::fault_action_t moderate_fault_action
);
   wire [7:0] a = request.address;
   wire [7:0] d = request.write_data;
   // Load beats writes
   wire w = request.write_strobe && !nvm_load;
   wire r = request.read_strobe;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_act; w && a == 8'h45 |=> moderate_fault_action == $past(d[1:0]); endproperty
   a_act: assert property (p_act) else $error("action");
   property p_nvm; nvm_load |=>
      moderate_fault_action == $past(nvm_defaults.action_select[1:0]); endproperty
   a_nvm: assert property (p_nvm) else $error("load");
   property p_rb45; (w && a == 8'h45) ##1 (r && a == 8'h45) |=> read_data == $past(d, 2);
   endproperty
   a_rb45: assert property (p_rb45) else $error("rb45");
   property p_rb46; (w && a == 8'h46) ##1 (r && a == 8'h46) |=> read_data == $past(d, 2);
   endproperty
   a_rb46: assert property (p_rb46) else $error("rb46");
   property p_rb48; (w && a == 8'h48) ##1 (r && a == 8'h48) |=> read_data == $past(d, 2);
   endproperty
   a_rb48: assert property (p_rb48) else $error("rb48");
   property p_g1; w && a == 8'h46 |=> ##1
      gpio_trigger[0] == ($past(d[0], 2) ? $past(d[1], 2) : $past(gpio_level[0])); endproperty
   a_g1: assert property (p_g1) else $error("g1");
   property p_g8; w && a == 8'h47 |=> ##1
      gpio_trigger[7] == ($past(d[6], 2) ? $past(d[7], 2) : $past(gpio_level[7])); endproperty
   a_g8: assert property (p_g8) else $error("g8");
   property p_g10; w && a == 8'h48 |=> ##1
      gpio_trigger[9] == ($past(d[2], 2) ? $past(d[3], 2) : $past(gpio_level[9])); endproperty
   a_g10: assert property (p_g10) else $error("g10");
   c_nvm: cover property (nvm_load);
   c_rd: cover property (r ##1 read_data != 8'h00);
   c_trig: cover property (gpio_trigger == 10'h3BB);
endmodule : fault_mask_props
bind fault_action_and_gpio_trigger_mask fault_mask_props props_u
(.clock(clock), .resetn(resetn), .request(request), .read_data(read_data),
 .nvm_defaults(nvm_defaults), .nvm_load(nvm_load), .gpio_level(gpio_level),
 .gpio_trigger(gpio_trigger), .moderate_fault_action(moderate_fault_action));
